/* rtl/cpusc_map.vh */
// Offsets, field positions, reset values and steps of the status and core-control block
`ifndef CPUSC_MAP_VH
`define CPUSC_MAP_VH
`define CPUSC_ADDR_STATUS 4'h0
`define CPUSC_ADDR_CORE 4'h1
`define CPUSC_ADDR_PM_ADDR 4'h2
`define CPUSC_ADDR_PM_LO 4'h3
`define CPUSC_ADDR_PM_HI 4'h4
`define CPUSC_ADDR_ALU 4'h5
`define CPUSC_ADDR_PC 4'h6
`define CPUSC_ADDR_PC_CTRL 4'h7
`define CPUSC_ST_OA 15
`define CPUSC_ST_OB 14
`define CPUSC_ST_SA 13
`define CPUSC_ST_SB 12
`define CPUSC_ST_OAB 11
`define CPUSC_ST_SAB 10
`define CPUSC_ST_DC 8
`define CPUSC_ST_IPL_HI 7
`define CPUSC_ST_IPL_LO 5
`define CPUSC_CC_EDT 11
`define CPUSC_CC_PRIO_LEVEL_MSB 3
`define CPUSC_STATUS_RST 16'h0000
`define CPUSC_CORE_RST 16'h0000
`define CPUSC_PC_STEP 16'h0002
`define CPUSC_PM_UPPER_MASK 16'h00FF
`endif

/* rtl/cpusc_pmem.v */
// Program memory: 24-bit locations, registered read
`timescale 1ns/1ps
module cpusc_pmem #(
    parameter AW = 8
) (
    input wire I_REF_CLK,
    input wire i_we,
    input wire [AW-1:0] i_addr,
    input wire [23:0] i_wdata,
    output reg [23:0] o_rdata
);
    reg [23:0] mem_r [0:(1<<AW)-1];
    always @(posedge I_REF_CLK) begin
        // Write-first, so a read straight after a commit sees the new word
        if (i_we) begin
            mem_r[i_addr] <= i_wdata;
            o_rdata <= i_wdata;
        end else begin
            o_rdata <= mem_r[i_addr];
        end
    end
endmodule // cpusc_pmem

/* rtl/cpusc_top.v */
// Status and core-control registers with program memory word access
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "cpusc_map.vh"
module cpusc_top #(
    parameter PM_AW = 8
) (
    input wire I_REF_CLK,
    input wire I_RESET,
    input wire [3:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire i_acc_a_ovf,
    input wire i_acc_b_ovf,
    input wire i_acc_a_sat,
    input wire i_acc_b_sat,
    input wire i_alu_valid,
    input wire i_alu_byte,
    input wire [15:0] i_alu_op_a,
    input wire [15:0] i_alu_op_b,
    input wire i_alu_sub,
    input wire i_nesting_disable,
    output reg [15:0] o_rdata,
    output reg [3:0] o_prio_level,
    output reg o_user_irq_mask,
    output reg o_early_loop_exit,
    output reg [15:0] o_pc
);
    localparam [15:0] status_rst = `CPUSC_STATUS_RST;
    localparam [15:0] core_rst = `CPUSC_CORE_RST;

    // Strobe qualified by one register index
    function hit;
        input strobe;
        input [3:0] addr;
        input [3:0] idx;
        begin
            hit = strobe && (addr == idx);
        end
    endfunction

    // Half carry from nibble or byte boundary of an add or subtract
    function half_carry;
        input byte_op;
        input sub;
        input [15:0] a;
        input [15:0] b;
        reg [8:0] s8;
        reg [4:0] s4;
        begin
            s8 = sub ? ({1'b0, a[7:0]} + {1'b0, ~b[7:0]} + 9'h001) : ({1'b0, a[7:0]} + {1'b0, b[7:0]});
            s4 = sub ? ({1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
            half_carry = byte_op ? s4[4] : s8[8];
        end
    endfunction

    // Sticky saturation: a hardware set wins over a clear in the same cycle
    function sticky_next;
        input current;
        input sat_event;
        input clear_write;
        input own_bit;
        input combined_bit;
        begin
            if (sat_event) begin
                sticky_next = 1'b1;
            end else if (clear_write && (!own_bit || !combined_bit)) begin
                sticky_next = 1'b0;
            end else begin
                sticky_next = current;
            end
        end
    endfunction

    // Lower-word alignment shared by memory address and PC load
    function [15:0] even_addr;
        input [15:0] value;
        begin
            even_addr = {value[15:1], 1'b0};
        end
    endfunction

    reg acc_a_overflow_r;
    reg acc_b_overflow_r;
    reg acc_a_sticky_sat_r;
    reg acc_a_sticky_sat_nxt;
    reg acc_b_sticky_sat_r;
    reg acc_b_sticky_sat_nxt;
    reg half_carry_flag_r;
    reg half_carry_flag_nxt;
    reg [2:0] prio_level_low_r;
    reg [2:0] prio_level_low_nxt;
    reg [4:0] alu_flags_r;
    reg [4:0] alu_flags_nxt;
    reg [15:0] core_control_r;
    reg [15:0] core_control_nxt;
    reg [15:0] pm_addr_r;
    reg [15:0] pm_addr_nxt;
    reg [15:0] pm_lo_hold_r;
    reg [15:0] pm_lo_hold_nxt;
    reg [15:0] pc_nxt;
    reg early_loop_exit_nxt;
    reg [15:0] rd_value;
    wire [23:0] pm_rdata;
    wire wr_status;
    wire wr_core;
    wire wr_pm_addr;
    wire wr_pm_lo;
    wire wr_pm_hi;
    wire wr_pc;
    wire wr_pc_ctrl;
    wire [PM_AW-1:0] pm_index_nxt;
    wire any_acc_overflow;
    wire any_acc_sticky_sat;

    // Write and read share one index, so at most one decode is live
    assign wr_status = hit(i_wr, i_addr, `CPUSC_ADDR_STATUS);
    assign wr_core = hit(i_wr, i_addr, `CPUSC_ADDR_CORE);
    assign wr_pm_addr = hit(i_wr, i_addr, `CPUSC_ADDR_PM_ADDR);
    assign wr_pm_lo = hit(i_wr, i_addr, `CPUSC_ADDR_PM_LO);
    assign wr_pm_hi = hit(i_wr, i_addr, `CPUSC_ADDR_PM_HI);
    assign wr_pc = hit(i_wr, i_addr, `CPUSC_ADDR_PC);
    assign wr_pc_ctrl = hit(i_wr, i_addr, `CPUSC_ADDR_PC_CTRL);
    // combined bits as OR of pairs
    assign any_acc_overflow = acc_a_overflow_r | acc_b_overflow_r;
    assign any_acc_sticky_sat = acc_a_sticky_sat_r | acc_b_sticky_sat_r;
    // Memory follows the next address, so its word is ready before a read
    assign pm_index_nxt = pm_addr_nxt[PM_AW:1];

    // 24-bit location, upper byte unimplemented
    // Only the low byte of the upper word is kept; the rest reads zero
    cpusc_pmem #(.AW(PM_AW)) cpusc_pmem_inst (
        .I_REF_CLK(I_REF_CLK),
        .i_we(wr_pm_hi),
        .i_addr(pm_index_nxt),
        .i_wdata({i_wdata[7:0], pm_lo_hold_r}),
        .o_rdata(pm_rdata)
    );

    // Status flag next state
    always @* begin
        acc_a_sticky_sat_nxt = acc_a_sticky_sat_r;
        acc_b_sticky_sat_nxt = acc_b_sticky_sat_r;
        half_carry_flag_nxt = half_carry_flag_r;
        prio_level_low_nxt = prio_level_low_r;
        alu_flags_nxt = alu_flags_r;
        // set beats clear, a write clears unless both own and combined bits are 1
        acc_a_sticky_sat_nxt = sticky_next(acc_a_sticky_sat_r, i_acc_a_sat, wr_status,
                                           i_wdata[`CPUSC_ST_SA], i_wdata[`CPUSC_ST_SAB]);
        acc_b_sticky_sat_nxt = sticky_next(acc_b_sticky_sat_r, i_acc_b_sat, wr_status,
                                           i_wdata[`CPUSC_ST_SB], i_wdata[`CPUSC_ST_SAB]);
        // half carry from ALU result, else software
        if (i_alu_valid) begin
            half_carry_flag_nxt = half_carry(i_alu_byte, i_alu_sub, i_alu_op_a, i_alu_op_b);
        end else if (wr_status) begin
            half_carry_flag_nxt = i_wdata[`CPUSC_ST_DC];
        end
        if (wr_status) begin
            alu_flags_nxt = i_wdata[4:0];
            if (!i_nesting_disable) begin
                prio_level_low_nxt = i_wdata[`CPUSC_ST_IPL_HI:`CPUSC_ST_IPL_LO];
            end
        end
    end

    // Control and memory staging next state
    always @* begin
        core_control_nxt = core_control_r;
        pm_addr_nxt = pm_addr_r;
        pm_lo_hold_nxt = pm_lo_hold_r;
        early_loop_exit_nxt = 1'b0;
        // early exit is a pulse, never stored
        if (wr_core) begin
            early_loop_exit_nxt = i_wdata[`CPUSC_CC_EDT];
            core_control_nxt = {3'h0, i_wdata[12], 1'b0, 3'h0, i_wdata[7:0]};
        end
        // addresses stay on even lower word
        if (wr_pm_addr) begin
            pm_addr_nxt = even_addr(i_wdata);
        end
        if (wr_pm_lo) begin
            pm_lo_hold_nxt = i_wdata;
        end
    end

    // Program counter next state
    always @* begin
        pc_nxt = o_pc;
        if (wr_pc) begin
            pc_nxt = even_addr(i_wdata);
        end else if (wr_pc_ctrl) begin
            if (i_wdata[0]) begin
                pc_nxt = o_pc + `CPUSC_PC_STEP;
            end else if (i_wdata[1]) begin
                pc_nxt = o_pc - `CPUSC_PC_STEP;
            end
        end
    end

    // Status flags
    always @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            acc_a_overflow_r <= status_rst[`CPUSC_ST_OA];
            acc_b_overflow_r <= status_rst[`CPUSC_ST_OB];
            acc_a_sticky_sat_r <= status_rst[`CPUSC_ST_SA];
            acc_b_sticky_sat_r <= status_rst[`CPUSC_ST_SB];
            half_carry_flag_r <= status_rst[`CPUSC_ST_DC];
            prio_level_low_r <= status_rst[`CPUSC_ST_IPL_HI:`CPUSC_ST_IPL_LO];
            alu_flags_r <= status_rst[4:0];
        end else begin
            acc_a_overflow_r <= i_acc_a_ovf;
            acc_b_overflow_r <= i_acc_b_ovf;
            acc_a_sticky_sat_r <= acc_a_sticky_sat_nxt;
            acc_b_sticky_sat_r <= acc_b_sticky_sat_nxt;
            half_carry_flag_r <= half_carry_flag_nxt;
            prio_level_low_r <= prio_level_low_nxt;
            alu_flags_r <= alu_flags_nxt;
        end
    end

    // Control register and memory staging
    always @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            core_control_r <= core_rst;
            pm_addr_r <= 16'h0000;
            pm_lo_hold_r <= 16'h0000;
            o_early_loop_exit <= 1'b0;
        end else begin
            core_control_r <= core_control_nxt;
            pm_addr_r <= pm_addr_nxt;
            pm_lo_hold_r <= pm_lo_hold_nxt;
            o_early_loop_exit <= early_loop_exit_nxt;
        end
    end

    // Program counter
    always @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            o_pc <= 16'h0000;
        end else begin
            o_pc <= pc_nxt;
        end
    end

    // level msb from core bit 3, masks users
    always @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            o_prio_level <= 4'h0;
            o_user_irq_mask <= 1'b0;
        end else begin
            o_prio_level <= {core_control_r[`CPUSC_CC_PRIO_LEVEL_MSB], prio_level_low_r};
            o_user_irq_mask <= core_control_r[`CPUSC_CC_PRIO_LEVEL_MSB];
        end
    end

    // Read word select; unmapped indices read zero
    always @* begin
        rd_value = 16'h0000;
        case (i_addr)
            `CPUSC_ADDR_STATUS: begin
                rd_value = {acc_a_overflow_r, acc_b_overflow_r, acc_a_sticky_sat_r, acc_b_sticky_sat_r,
                            any_acc_overflow, any_acc_sticky_sat,
                            1'b0, half_carry_flag_r, prio_level_low_r, alu_flags_r};
            end
            `CPUSC_ADDR_CORE: begin
                rd_value = core_control_r;
            end
            `CPUSC_ADDR_PM_ADDR: begin
                rd_value = pm_addr_r;
            end
            `CPUSC_ADDR_PM_LO: begin
                rd_value = pm_rdata[15:0];
            end
            // upper byte of upper word reads zero
            `CPUSC_ADDR_PM_HI: begin
                rd_value = {8'h00, pm_rdata[23:16]} & `CPUSC_PM_UPPER_MASK;
            end
            `CPUSC_ADDR_PC: begin
                rd_value = o_pc;
            end
            default: begin
                rd_value = 16'h0000;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= rd_value;
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule // cpusc_top

/* tb/cpusc_top_asserts.sv */
// Checker for the status and core-control block ports
`timescale 1ns/1ps
module cpusc_top_chk (
    input wire I_REF_CLK,
    input wire I_RESET,
    input wire [3:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] o_rdata,
    input wire [3:0] o_prio_level,
    input wire o_user_irq_mask,
    input wire o_early_loop_exit,
    input wire [15:0] o_pc
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);
    sequence core_wr_s; i_wr && i_addr == 4'h1; endsequence
    sequence pc_up_s; i_wr && i_addr == 4'h7 && i_wdata[0]; endsequence
    exit_pulse_a: assert property (core_wr_s ##0 i_wdata[11] |=> o_early_loop_exit)
        else $error("early exit pulse missing");
    exit_cause_a: assert property (o_early_loop_exit |-> $past(i_wr && i_addr == 4'h1 && i_wdata[11]))
        else $error("early exit without write");
    level_msb_a: assert property (core_wr_s |=> ##1 o_prio_level[3] == $past(i_wdata[3], 2))
        else $error("level msb not from core bit 3");
    irq_mask_a: assert property (o_user_irq_mask == o_prio_level[3])
        else $error("mask differs from level msb");
    pc_even_a: assert property (o_pc[0] == 1'h0)
        else $error("pc odd");
    pc_step_a: assert property (pc_up_s |=> o_pc == $past(o_pc) + 16'h0002)
        else $error("pc step not two");
    exit_reads_zero_a: assert property (i_rd && i_addr == 4'h1 |=> o_rdata[11] == 1'h0)
        else $error("early exit bit read as one");
    combined_bits_a: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[11] == (o_rdata[15] | o_rdata[14])
        && o_rdata[10] == (o_rdata[13] | o_rdata[12]))
        else $error("combined bits not OR");
    pm_upper_a: assert property (i_rd && i_addr == 4'h4 |=> o_rdata[15:8] == 8'h00)
        else $error("upper byte not zero");
endmodule // cpusc_top_chk
bind cpusc_top cpusc_top_chk cpusc_top_chk_inst (.I_REF_CLK, .I_RESET, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_prio_level, .o_user_irq_mask, .o_early_loop_exit, .o_pc);

/* tb/tb_cpu_status_core_control.sv */
// Self-checking bench for the status and core-control block
`timescale 1ns/1ps
module tb_cpu_status_core_control;
    reg ref_clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, a_ovf = 1'h0, b_ovf = 1'h0, a_sat = 1'h0;
    reg b_sat = 1'h0, alu_v = 1'h0, alu_byte = 1'h0, alu_sub = 1'h0, nest = 1'h0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0000, op_a = 16'h0000, op_b = 16'h0000;
    reg [39:0] rows [0:7];
    wire [15:0] rdata, pc;
    wire [3:0] prio;
    wire mask, ext;
    integer err_total = 0, checks = 0, cyc = 0, k;
    cpusc_top cpusc_top_inst (.I_REF_CLK(ref_clk), .I_RESET(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_acc_a_ovf(a_ovf), .i_acc_b_ovf(b_ovf), .i_acc_a_sat(a_sat),
        .i_acc_b_sat(b_sat), .i_alu_valid(alu_v), .i_alu_byte(alu_byte), .i_alu_op_a(op_a),
        .i_alu_op_b(op_b), .i_alu_sub(alu_sub), .i_nesting_disable(nest), .o_rdata(rdata),
        .o_prio_level(prio), .o_user_irq_mask(mask), .o_early_loop_exit(ext), .o_pc(pc));
    always #10 ref_clk = ~ref_clk;
    task tally_and_finish; begin
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    end endtask
    // Generous ceiling; the sequence needs well under 200 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
    task chk(input [47:0] nm, input [15:0] seen, input [15:0] exp); begin
        checks = checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
        end
    end endtask
    // Strobe released at the taking edge, so back-to-back calls never collide
    task bus(input w, input [3:0] a, input [15:0] d); begin
        wr <= w; rd <= !w; addr <= a; wdata <= d;
        @(posedge ref_clk);
        wr <= 1'h0; rd <= 1'h0;
        #1;
    end endtask
    task rdc(input [3:0] a, input [15:0] e); begin
        bus(1'h0, a, 16'h0000);
        chk("rdata", rdata, e);
    end endtask
    task alu(input by, input sb, input [15:0] x, input [15:0] y, input [15:0] e); begin
        alu_v <= 1'h1; alu_byte <= by; alu_sub <= sb; op_a <= x; op_b <= y;
        @(posedge ref_clk);
        alu_v <= 1'h0;
        #1;
        rdc(4'h0, e);
    end endtask
    initial begin
        rows[0] = {4'h1, 16'h0808, 4'h1, 16'h0008};
        rows[1] = {4'h1, 16'h0000, 4'h1, 16'h0000};
        rows[2] = {4'h0, 16'h01E5, 4'h0, 16'h01E5};
        rows[3] = {4'h5, 16'hFFFF, 4'h5, 16'h0000};
        rows[4] = {4'h2, 16'h0011, 4'h2, 16'h0010};
        rows[5] = {4'h3, 16'hBEEF, 4'h5, 16'h0000};
        rows[6] = {4'h4, 16'hA5C3, 4'h4, 16'h00C3};
        rows[7] = {4'h5, 16'h0000, 4'h3, 16'hBEEF};
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        #1;
        for (k = 0; k < 8; k = k + 1) begin
            bus(1'h1, rows[k][39:36], rows[k][35:20]);
            rdc(rows[k][19:16], rows[k][15:0]);
        end
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        #1;
        rdc(4'h0, 16'h0000);
        a_ovf <= 1'h1;
        bus(1'h1, 4'h5, 16'h0000);
        rdc(4'h0, 16'h8800);
        a_ovf <= 1'h0; b_ovf <= 1'h1;
        bus(1'h1, 4'h5, 16'h0000);
        rdc(4'h0, 16'h4800);
        b_ovf <= 1'h0; a_sat <= 1'h1;
        bus(1'h1, 4'h5, 16'h0000);
        a_sat <= 1'h0;
        bus(1'h1, 4'h0, 16'h3400);
        rdc(4'h0, 16'h2400);
        bus(1'h1, 4'h0, 16'h3000);
        rdc(4'h0, 16'h0000);
        nest <= 1'h1;
        bus(1'h1, 4'h0, 16'h00E0);
        rdc(4'h0, 16'h0000);
        nest <= 1'h0;
        bus(1'h1, 4'h0, 16'h00E0);
        rdc(4'h0, 16'h00E0);
        chk("prio", {12'h000, prio}, 16'h0007);
        bus(1'h1, 4'h1, 16'h0808);
        chk("exit", {15'h0000, ext}, 16'h0001);
        bus(1'h1, 4'h5, 16'h0000);
        chk("exit", {15'h0000, ext}, 16'h0000);
        chk("prio", {12'h000, prio}, 16'h000F);
        chk("mask", {15'h0000, mask}, 16'h0001);
        alu(1'h1, 1'h0, 16'h000F, 16'h0001, 16'h01E0);
        alu(1'h0, 1'h0, 16'h000F, 16'h0001, 16'h00E0);
        alu(1'h0, 1'h0, 16'h00F0, 16'h0010, 16'h01E0);
        alu(1'h1, 1'h1, 16'h0010, 16'h0001, 16'h00E0);
        bus(1'h1, 4'h6, 16'h0124);
        bus(1'h1, 4'h7, 16'h0001);
        chk("pc", pc, 16'h0126);
        bus(1'h1, 4'h7, 16'h0002);
        chk("pc", pc, 16'h0124);
        tally_and_finish;
    end
endmodule // tb_cpu_status_core_control
